// >>> include/evr_consts.vh
// constants for the event channel routing register block
`ifndef EVR_CONSTS_VH
`define EVR_CONSTS_VH

// register indices (printed offsets)
`define EVR_IDX_SRC_SEL      12'hF98
`define EVR_IDX_SRC_DATA     12'hF99
`define EVR_IDX_DST_SEL      12'hF9A
`define EVR_IDX_DST_DATA     12'hF9B
`define EVR_ADDR_W           14

// field layout
`define EVR_SRC_IDX_W        3
`define EVR_SRC_SEL_MASK     8'h0F
`define EVR_SRC_CODE_W       7
`define EVR_DST_IDX_W        6
`define EVR_DST_CONNECT_BIT  3
`define EVR_DST_FIELD_W      4
`define EVR_NUM_CH           8
`define EVR_NUM_DST          64
`define EVR_RESET_BYTE       8'h00

// source select codes
`define EVR_SRC_OFF          7'h00
`define EVR_SRC_SOFT         7'h01
`define EVR_SRC_T0A          7'h10
`define EVR_SRC_T0B          7'h11
`define EVR_SRC_T1A          7'h14
`define EVR_SRC_T1B          7'h15
`define EVR_SRC_T2A          7'h18
`define EVR_SRC_T2B          7'h19
`define EVR_SRC_TA           7'h1A
`define EVR_SRC_MCT_BASE     7'h1C
`define EVR_SRC_CMP0         7'h40
`define EVR_SRC_CMP1         7'h41
`define EVR_SRC_CMPWIN       7'h42
`define EVR_SRC_PA_BASE      7'h50
`define EVR_SRC_PC_BASE      7'h64
`define EVR_SRC_PE_BASE      7'h73

`endif

// >>> core/evr_chan_src.v
// one event channel: source code to channel level multiplexer
`timescale 1ns/10ps
`include "evr_consts.vh"

module evr_chan_src
(
    input  wire [6:0] source_select_code,
    input  wire [3:0] tmr_out,
    input  wire       tmra_out,
    input  wire [3:0] mct_out,
    input  wire       cmp0_out,
    input  wire       cmp1_out,
    input  wire       comparator_window_detect,
    input  wire [7:0] porta_pin,
    input  wire [3:0] portc_hi_pin,
    input  wire [3:0] porte_lo_pin,
    output reg        chan_level
);

    // tmr_out: [0] timer 0, [1] timer 1, [2] timer 2, [3] unused
    always @*
    begin
        case (source_select_code)
            `EVR_SRC_OFF:    chan_level = 1'b0;
            `EVR_SRC_SOFT:   chan_level = 1'b1;
            `EVR_SRC_T0A,
            `EVR_SRC_T0B:    chan_level = tmr_out[0];
            `EVR_SRC_T1A,
            `EVR_SRC_T1B:    chan_level = tmr_out[1];
            `EVR_SRC_T2A,
            `EVR_SRC_T2B:    chan_level = tmr_out[2];
            `EVR_SRC_TA:     chan_level = tmra_out;
            7'h1C, 7'h1D,
            7'h1E, 7'h1F:    chan_level = mct_out[source_select_code[1:0]];
            `EVR_SRC_CMP0:   chan_level = cmp0_out;
            `EVR_SRC_CMP1:   chan_level = cmp1_out;
            `EVR_SRC_CMPWIN: chan_level = comparator_window_detect;
            7'h50, 7'h51, 7'h52, 7'h53,
            7'h54, 7'h55, 7'h56, 7'h57:
                             chan_level = porta_pin[source_select_code[2:0]];
            7'h64, 7'h65,
            7'h66, 7'h67:    chan_level = portc_hi_pin[source_select_code[1:0]];
            7'h73:           chan_level = porte_lo_pin[0];
            7'h74:           chan_level = porte_lo_pin[1];
            7'h75:           chan_level = porte_lo_pin[2];
            7'h76:           chan_level = porte_lo_pin[3];
            default:         chan_level = 1'b0;
        endcase
    end

endmodule

// >>> core/evr_routing_regs.v
// event channel routing fabric with apb register window
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`include "evr_consts.vh"
//
// Behaviour
// - four byte registers: source index, source data, destination index, destination data
// - source index low bits 2..0 pick the channel source subregister
// - source data moves 7 bits to or from indexed subregister; bit 7 reads zero
// - each channel holds a 7-bit source code, reset to zero
// - code zero holds the channel low
// - code one drives channel high until another code is written
// - codes 1Ch..1Fh route multi-channel timer outputs A..D
// - codes 40h,41h,42h route comparator 0, comparator 1, window detect
// - destination index is 6 bits; bits 7..6 read zero
// - destination 04h is the converter start trigger
// - destinations 10h..1Ah are timer 0,1,2 inputs and timer A input
// - destinations 1Ch..1Fh multi-channel timer inputs A..D, 20h its general input
// - destinations 30h..33h are the four routed pin outputs
// - destination data reaches the subregister picked by destination index
// - destination holds connect bit 3 and channel pick 2..0; unconnected drives 0
// - no synchroniser on channels; pure multiplexing

module evr_routing_regs
(
    input  wire                    pclk,
    input  wire                    presetn,
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [`EVR_ADDR_W-1:0]  paddr,
    input  wire [31:0]             pwdata,
    output wire [31:0]             prdata,
    output wire                    pready,
    output wire                    pslverr,
    input  wire [3:0]              tmr_out,
    input  wire                    tmra_out,
    input  wire [3:0]              mct_out,
    input  wire                    cmp0_out,
    input  wire                    cmp1_out,
    input  wire                    comparator_window_detect,
    input  wire [7:0]              porta_pin,
    input  wire [3:0]              portc_hi_pin,
    input  wire [3:0]              porte_lo_pin,
    output wire [7:0]              channel_level,
    output wire                    adc_convert_trig,
    output wire [5:0]              timer_in,
    output wire                    timera_in,
    output wire [3:0]              mct_in,
    output wire                    mct_gen_in,
    output wire [3:0]              routed_pin_output
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // destination slot implemented at this index
    function dst_valid;
        input [5:0] idx;
        begin
            case (idx)
                6'h04, 6'h10, 6'h11, 6'h14, 6'h15, 6'h18, 6'h19, 6'h1A,
                6'h1C, 6'h1D, 6'h1E, 6'h1F, 6'h20,
                6'h30, 6'h31, 6'h32, 6'h33: dst_valid = 1'b1;
                default:                    dst_valid = 1'b0;
            endcase
        end
    endfunction

    // register index is four times into the byte address
    function [11:0] reg_index;
        input [`EVR_ADDR_W-1:0] a;
        begin
            reg_index = a[`EVR_ADDR_W-1:2];
        end
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg  [2:0]               src_index_r;
    reg  [5:0]               dst_index_r;
    reg  [6:0]               chan_src_r [0:`EVR_NUM_CH-1];
    reg  [3:0]               dst_set_r  [0:`EVR_NUM_DST-1];
    reg  [31:0]              prdata_r;
    reg  [7:0]               rd_byte;
    wire [11:0]              idx;
    wire                     wr_en;
    wire                     rd_en;
    wire                     mapped;
    integer                  i;

    assign idx    = reg_index(paddr);
    assign mapped = (idx == `EVR_IDX_SRC_SEL) || (idx == `EVR_IDX_SRC_DATA) ||
                    (idx == `EVR_IDX_DST_SEL) || (idx == `EVR_IDX_DST_DATA);
    assign wr_en  = psel & penable & pwrite & mapped;
    assign rd_en  = psel & ~penable & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_r;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_index_r <= 3'h0;
            dst_index_r <= 6'h00;
            for (i = 0; i < `EVR_NUM_CH; i = i + 1)
                chan_src_r[i] <= 7'h00;
            for (i = 0; i < `EVR_NUM_DST; i = i + 1)
                dst_set_r[i] <= 4'h0;
        end
        else if (wr_en)
        begin
            case (idx)
                `EVR_IDX_SRC_SEL:
                    src_index_r <= pwdata[2:0];
                `EVR_IDX_SRC_DATA:
                    chan_src_r[src_index_r] <= pwdata[6:0];
                `EVR_IDX_DST_SEL:
                    dst_index_r <= pwdata[5:0];
                `EVR_IDX_DST_DATA:
                    if (dst_valid(dst_index_r))
                        dst_set_r[dst_index_r] <= pwdata[3:0];
                default:
                    dst_index_r <= dst_index_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    always @*
    begin
        case (idx)
            `EVR_IDX_SRC_SEL:  rd_byte = {5'h00, src_index_r};
            `EVR_IDX_SRC_DATA: rd_byte = {1'b0, chan_src_r[src_index_r]};
            `EVR_IDX_DST_SEL:  rd_byte = {2'h0, dst_index_r};
            `EVR_IDX_DST_DATA: rd_byte = dst_valid(dst_index_r) ?
                                         {4'h0, dst_set_r[dst_index_r]} :
                                         `EVR_RESET_BYTE;
            default:           rd_byte = `EVR_RESET_BYTE;
        endcase
    end

    // read data captured in setup cycle, stands through access phase
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_r <= 32'h00000000;
        else if (rd_en)
            prdata_r <= {24'h000000, rd_byte};
    end

    // ----------------------------------------------------------------
    // channel multiplexers
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `EVR_NUM_CH; g = g + 1)
        begin : g_chan
            evr_chan_src u_src
            (
                .source_select_code       (chan_src_r[g]),
                .tmr_out                  (tmr_out),
                .tmra_out                 (tmra_out),
                .mct_out                  (mct_out),
                .cmp0_out                 (cmp0_out),
                .cmp1_out                 (cmp1_out),
                .comparator_window_detect (comparator_window_detect),
                .porta_pin                (porta_pin),
                .portc_hi_pin             (portc_hi_pin),
                .porte_lo_pin             (porte_lo_pin),
                .chan_level               (channel_level[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // destination gating
    // ----------------------------------------------------------------
    function dst_level;
        input [3:0] setting;
        input [7:0] chans;
        begin
            dst_level = setting[`EVR_DST_CONNECT_BIT] & chans[setting[2:0]];
        end
    endfunction

    assign adc_convert_trig = dst_level(dst_set_r[6'h04], channel_level);
    assign timer_in[0] = dst_level(dst_set_r[6'h10], channel_level);
    assign timer_in[1] = dst_level(dst_set_r[6'h11], channel_level);
    assign timer_in[2] = dst_level(dst_set_r[6'h14], channel_level);
    assign timer_in[3] = dst_level(dst_set_r[6'h15], channel_level);
    assign timer_in[4] = dst_level(dst_set_r[6'h18], channel_level);
    assign timer_in[5] = dst_level(dst_set_r[6'h19], channel_level);
    assign timera_in   = dst_level(dst_set_r[6'h1A], channel_level);

    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_dst4
            assign mct_in[g] = dst_level(dst_set_r[6'h1C + g], channel_level);
            assign routed_pin_output[g] = dst_level(dst_set_r[6'h30 + g], channel_level);
        end
    endgenerate

    assign mct_gen_in = dst_level(dst_set_r[6'h20], channel_level);

endmodule

// >>> tb/evr_chk.sv
// assertion checker for the event routing register block
`timescale 1ns/10ps
`include "evr_consts.vh"
// ----------------------------------------
// checker
// ----------------------------------------
module evr_chk
(
    input wire                   pclk,
    input wire                   presetn,
    input wire                   psel,
    input wire                   penable,
    input wire                   pwrite,
    input wire [`EVR_ADDR_W-1:0] paddr,
    input wire [31:0]            prdata,
    input wire                   pready,
    input wire                   pslverr,
    input wire [7:0]             channel_level,
    input wire                   adc_convert_trig,
    input wire [5:0]             timer_in,
    input wire [3:0]             routed_pin_output
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [10:0] dsts   = {routed_pin_output, timer_in, adc_convert_trig};
    wire        wr_acc = psel && penable && pwrite;
    wire        mapped = paddr[13:4] == 10'h3E6;
    sequence s_rd(a);
        psel && penable && !pwrite && paddr == {a, 2'h0};
    endsequence
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
        else $error("no error on unmapped access");
    a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
        else $error("error on mapped access");
    a_srcsel_bits: assert property (s_rd(`EVR_IDX_SRC_SEL) |-> prdata[31:3] == 0)
        else $error("source index upper bits set");
    a_srcdata_bits: assert property (s_rd(`EVR_IDX_SRC_DATA) |-> prdata[31:7] == 0)
        else $error("source data bit 7 set");
    a_dstsel_bits: assert property (s_rd(`EVR_IDX_DST_SEL) |-> prdata[31:6] == 0)
        else $error("destination index upper bits set");
    a_dstdata_bits: assert property (s_rd(`EVR_IDX_DST_DATA) |-> prdata[31:4] == 0)
        else $error("destination data upper bits set");
    a_rdata_hold: assert property (!$stable(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("read data moved without read");
    a_dst_cause: assert property (!$stable(dsts) |-> !$stable(channel_level) || $past(wr_acc))
        else $error("destination moved without cause");
    a_reset_quiet: assert property (!$past(presetn) |-> channel_level == 0 && dsts == 0)
        else $error("outputs not low after reset");
endmodule
bind evr_routing_regs evr_chk chk_u
(
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_level(channel_level), .adc_convert_trig(adc_convert_trig),
    .timer_in(timer_in), .routed_pin_output(routed_pin_output)
);

// >>> tb/evr_src_model.sv
// far-side source levels model
`timescale 1ns/10ps
module evr_src_model
(
    input  wire [27:0] pat,
    output wire [3:0]  tmr_out,
    output wire        tmra_out,
    output wire [3:0]  mct_out,
    output wire        cmp0_out,
    output wire        cmp1_out,
    output wire        cmp_win,
    output wire [7:0]  porta_pin,
    output wire [3:0]  portc_hi_pin,
    output wire [3:0]  porte_lo_pin
);
    // sources are plain levels, no clocking of their own
    assign {porte_lo_pin, portc_hi_pin, porta_pin, cmp_win, cmp1_out, cmp0_out, mct_out,
            tmra_out, tmr_out} = pat;
endmodule

// >>> tb/event_channel_routing_regs_tb_top.sv
// self-checking bench for the event routing register block
`timescale 1ns/10ps
`include "evr_consts.vh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s exp %0h got %0h", n, e, g); end end
module event_channel_routing_regs_tb_top;
    reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    reg  [13:0] paddr = 0;
    reg  [31:0] pwdata = 0, rd;
    reg         er;
    reg  [27:0] pat = 0, tmp;
    wire [31:0] prdata;
    wire        pready, pslverr, adc, ta, tai, mgen, c0, c1, cw;
    wire [7:0]  chl, pa;
    wire [5:0]  tmi;
    wire [3:0]  mci, rpo, tmo, mco, pc, pe;
    wire [16:0] dsts = {rpo, mgen, mci, tai, tmi, adc};
    byte        dl[17] = '{8'h04, 8'h10, 8'h11, 8'h14, 8'h15, 8'h18, 8'h19, 8'h1A, 8'h1C,
                           8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h30, 8'h31, 8'h32, 8'h33};
    int         fails = 0, comparisons = 0, cyc = 0, i, k, b;
    evr_src_model src_u (.pat(pat), .tmr_out(tmo), .tmra_out(ta), .mct_out(mco),
        .cmp0_out(c0), .cmp1_out(c1), .cmp_win(cw), .porta_pin(pa), .portc_hi_pin(pc),
        .porte_lo_pin(pe));
    evr_routing_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tmr_out(tmo),
        .tmra_out(ta), .mct_out(mco), .cmp0_out(c0), .cmp1_out(c1),
        .comparator_window_detect(cw), .porta_pin(pa), .portc_hi_pin(pc),
        .porte_lo_pin(pe), .channel_level(chl), .adc_convert_trig(adc), .timer_in(tmi),
        .timera_in(tai), .mct_in(mci), .mct_gen_in(mgen), .routed_pin_output(rpo));
    always #4 pclk = ~pclk;
    // ----------------------------------------
    // apb master and helpers
    // ----------------------------------------
    task automatic xfer(input bit w, input [11:0] idx, input [7:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'hA5A5A5, d};
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic rchk(input [11:0] idx, input [7:0] e);
        xfer(0, idx, 8'h00);
        `CHK("read", {24'h0, e}, rd)
    endtask
    function automatic int sbit(input int c);
        if (c == 16 || c == 17) return 0;
        if (c == 20 || c == 21) return 1;
        if (c == 24 || c == 25) return 2;
        if (c == 26) return 4;
        if (c >= 28 && c <= 31) return c - 23;
        if (c >= 64 && c <= 66) return c - 55;
        if (c >= 80 && c <= 87) return c - 68;
        if (c >= 100 && c <= 103) return c - 80;
        if (c >= 115 && c <= 118) return c - 91;
        return -1;
    endfunction
    task wrap_up;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            wrap_up;
        end
    end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (i = 0; i < 4; i++) rchk(12'(12'hF98 + i), 8'h00);
        rchk(12'hF9C, 8'h00);
        `CHK("slverr", 1'b1, er)
        xfer(1, 12'hF98, 8'h0F);
        rchk(12'hF98, 8'h07);
        `CHK("slverr", 1'b0, er)
        for (k = 0; k < 128; k++)
        begin
            b = sbit(k);
            if (k > 1 && b < 0) continue;
            xfer(1, 12'hF98, 8'(k % 8));
            xfer(1, 12'hF99, 8'(k));
            rchk(12'hF99, 8'(k));
            tmp = k == 0 ? 28'hFFFFFFF : k == 1 ? 28'h0 : 28'h1 << b;
            pat <= tmp;
            @(negedge pclk) `CHK("chan", k != 0, chl[k % 8])
            @(posedge pclk) pat <= ~tmp;
            @(negedge pclk) `CHK("chan", k == 1, chl[k % 8])
            @(posedge pclk);
        end
        for (i = 0; i < 8; i++)
        begin
            xfer(1, 12'hF98, 8'(i));
            xfer(1, 12'hF99, 8'(i % 2));
        end
        for (k = 0; k < 17; k++)
        begin
            xfer(1, 12'hF9A, dl[k]);
            xfer(1, 12'hF9B, 8'(8 + k % 8));
            rchk(12'hF9B, 8'(8 + k % 8));
            @(negedge pclk) `CHK("dest", 17'(k % 2) << k, dsts)
            @(posedge pclk) xfer(1, 12'hF9B, 8'(k % 8));
            @(negedge pclk) `CHK("dest", 17'h0, dsts)
            @(posedge pclk);
        end
        rchk(12'hF9A, 8'h33);
        xfer(1, 12'hF9A, 8'h05);
        xfer(1, 12'hF9B, 8'h0F);
        rchk(12'hF9B, 8'h00);
        `CHK("dest", 17'h0, dsts)
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rchk(12'hF99, 8'h00);
        `CHK("chan", 8'h00, chl)
        wrap_up;
    end
endmodule
